/* File: rtl/lpw_ctrl.sv */
// Purpose: low-power mode selection, clock gating, flags and wake-up control
// Assumes: halt and clr_wdt are one-cycle pulses from the core on pclk
// Notes:   APB slave with zero wait states; ticks and port pins synchronised
`timescale 1ns/1ps
// Notes on behaviour
// - halt, idle off, wdt/lvd on: sub sleep
// - sub sleep: sys and timebase clocks stop
// - sub sleep entry clears wdt if sub-clocked or lvd off
// - halt sets power-down, clears time-out flag
// - memory, registers, ports frozen while asleep
// - halt, idle on, keep off: idle stopped
// - idle stopped: sys off, timebase, sub on
// - idle stopped: wdt cleared if sub-clocked
// - halt, idle on, keep on: idle running
// - idle running: all clocks stay on
// - idle running entry clears enabled wdt
// - wake on reset, port edge, irq, overflow
// - reset wake full reset; overflow wdt reset
// - power-down clear on powerup, wdt clear
// - overflow in sleep sets time-out, wakes
// - enabled port falling edge wakes, resumes
// - disabled irq or full stack: resume only
// - enabled irq, stack free: take interrupt
// - irq already pending at halt: no wake
// - one shared counter, crystal before low
// - deep wake waits for high-speed ready
// - fast wake runs system from sub clock
// - halt, idle off, wdt lvd off: deepest
// - sub clock until 1024 crystal ticks
module lpw_ctrl #(
    parameter int NIRQ = 8,
    parameter int NPA  = 8
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            ce,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // core
    input  wire logic            halt,
    input  wire logic            clr_wdt,
    input  wire logic            stack_full,
    input  wire logic [NIRQ-1:0] irq_req,
    input  wire logic [NIRQ-1:0] irq_en,
    // configuration
    input  wire logic            wdt_cfg_en,
    input  wire logic            wdt_src_sub,
    input  wire logic            lvd_en,
    input  wire logic            hxt_sel,
    input  wire logic            lxt_sel,
    // wake sources and oscillator ticks
    input  wire logic            ext_reset_req,
    input  wire logic            wdt_overflow,
    input  wire logic [NPA-1:0]  port_a,
    input  wire logic            hxt_tick,
    input  wire logic            lxt_tick,
    // clock gating
    output logic                 sys_clk_en,
    output logic                 tb_clk_en,
    output logic                 sub_clk_en,
    output logic                 run_on_sub,
    output logic                 hxt_osc_en,
    output logic                 lxt_osc_en,
    // core control
    output logic                 cpu_hold,
    output logic                 freeze,
    output logic                 resume,
    output logic                 irq_take,
    output logic                 sys_reset_req,
    output logic                 wdt_reset_req,
    // watchdog control
    output logic                 wdt_clear,
    output logic                 wdt_run
);

    lpw_pkg::lpw_state_e state_q;
    lpw_pkg::lpw_state_e state_d;
    lpw_pkg::lpw_sst_e   phase_q;
    logic [7:0]          ctrl_q;
    logic [7:0]          wake_q;
    logic                pdf_q;
    logic                to_q;
    logic                hto_q;
    logic                lto_q;
    logic [9:0]          sst_cnt_q;
    logic [NIRQ-1:0]     armed_q;
    logic [NPA-1:0]      pa_fall;
    logic [1:0]          tick_rise;
    logic                wdt_en;
    logic                low_pw;
    logic                run_halt;
    logic                wake_pa;
    logic                wake_irq;
    logic                take_irq;
    logic                wake_any;
    logic                need_stab;
    logic                need_lxt;
    logic                sst_tick;
    logic                sst_done;
    logic                wdt_clr_entry;
    logic                apb_wr;
    logic                apb_setup;
    logic                addr_ok;

    // ========================================================================
    // decoding
    function automatic lpw_pkg::lpw_state_e lp_mode(input logic idle,
                                                   input logic keep,
                                                   input logic wdt_or_lvd);
        if (idle) begin
            lp_mode = keep ? lpw_pkg::ST_IDL1 : lpw_pkg::ST_IDL0;
        end else begin
            lp_mode = wdt_or_lvd ? lpw_pkg::ST_SLP1 : lpw_pkg::ST_SLP0;
        end
    endfunction : lp_mode

    function automatic logic is_low(input lpw_pkg::lpw_state_e s);
        is_low = (s == lpw_pkg::ST_SLP0) || (s == lpw_pkg::ST_SLP1) ||
                 (s == lpw_pkg::ST_IDL0) || (s == lpw_pkg::ST_IDL1);
    endfunction : is_low

    // ========================================================================
    // pin synchronisers
    lpw_pin_sync #(.WIDTH(NPA)) u_pa_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin     (port_a),
        .level   (),
        .rise    (),
        .fall    (pa_fall)
    );

    lpw_pin_sync #(.WIDTH(2)) u_tick_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin     ({lxt_tick, hxt_tick}),
        .level   (),
        .rise    (tick_rise),
        .fall    ()
    );

    // ========================================================================
    // apb slave
    assign apb_setup = ce && psel && !penable;
    assign apb_wr    = ce && psel && penable && pwrite;
    assign addr_ok   = (paddr == lpw_pkg::ADDR_CTRL) || (paddr == lpw_pkg::ADDR_WAKE) ||
                       (paddr == lpw_pkg::ADDR_STAT);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= lpw_pkg::CTRL_RST;
            wake_q <= lpw_pkg::WAKE_RST;
        end else if (apb_wr) begin
            if (paddr == lpw_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == lpw_pkg::ADDR_WAKE) begin
                wake_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup) begin
            prdata <= '0;
            case (paddr)
                lpw_pkg::ADDR_CTRL: prdata[7:0] <= ctrl_q;
                lpw_pkg::ADDR_WAKE: prdata[7:0] <= wake_q;
                lpw_pkg::ADDR_STAT: begin
                    prdata[lpw_pkg::STAT_PDF_BIT]  <= pdf_q;
                    prdata[lpw_pkg::STAT_TO_BIT]   <= to_q;
                    prdata[lpw_pkg::STAT_HTO_BIT]  <= hto_q;
                    prdata[lpw_pkg::STAT_LTO_BIT]  <= lto_q;
                    prdata[lpw_pkg::STAT_MODE_LSB +: 3] <= state_q;
                end
                default: prdata <= '0;
            endcase
        end
    end

    // ========================================================================
    // wake-up sources
    assign wdt_en   = wdt_cfg_en || (ctrl_q[lpw_pkg::CTRL_WDT_LSB +: 4] != lpw_pkg::WDT_OFF_CODE);
    assign low_pw   = is_low(state_q);
    assign run_halt = ce && (state_q == lpw_pkg::ST_RUN) && halt;
    assign wake_pa  = |(pa_fall & wake_q[NPA-1:0]);
    assign wake_irq = |(irq_req & armed_q);
    assign take_irq = |(irq_req & armed_q & irq_en) && !stack_full;
    assign wake_any = ext_reset_req || wdt_overflow || wake_pa || wake_irq;
    assign need_stab = hxt_sel && (state_q != lpw_pkg::ST_IDL1);
    assign need_lxt  = lxt_sel && (state_q == lpw_pkg::ST_SLP0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= '0;
        end else if (run_halt) begin
            armed_q <= ~irq_req;
        end
    end

    // ========================================================================
    // mode state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            lpw_pkg::ST_RUN: begin
                if (halt) begin
                    state_d = lp_mode(ctrl_q[lpw_pkg::CTRL_IDLE_BIT],
                                      ctrl_q[lpw_pkg::CTRL_KEEP_BIT],
                                      wdt_en || lvd_en);
                end
            end
            lpw_pkg::ST_SLP0, lpw_pkg::ST_SLP1, lpw_pkg::ST_IDL0, lpw_pkg::ST_IDL1: begin
                if (wake_any) begin
                    if (!need_stab) begin
                        state_d = lpw_pkg::ST_RUN;
                    end else if (ctrl_q[lpw_pkg::CTRL_FAST_BIT] &&
                                 state_q != lpw_pkg::ST_SLP0) begin
                        state_d = lpw_pkg::ST_FAST;
                    end else begin
                        state_d = lpw_pkg::ST_STAB;
                    end
                end
            end
            lpw_pkg::ST_STAB, lpw_pkg::ST_FAST: begin
                if (hto_q) begin
                    state_d = lpw_pkg::ST_RUN;
                end
            end
            default: state_d = lpw_pkg::ST_STAB;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= lpw_pkg::ST_STAB;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // ========================================================================
    // shared stabilisation counter
    assign sst_tick = (phase_q == lpw_pkg::SST_HXT) ? tick_rise[0] : tick_rise[1];
    assign sst_done = sst_tick && (sst_cnt_q == lpw_pkg::SST_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q   <= lpw_pkg::SST_HXT;
            sst_cnt_q <= '0;
            hto_q     <= 1'b0;
            lto_q     <= 1'b0;
        end else if (ce) begin
            if (low_pw && wake_any && need_stab) begin
                phase_q   <= lpw_pkg::SST_HXT;
                sst_cnt_q <= '0;
                hto_q     <= 1'b0;
                if (need_lxt) begin
                    lto_q <= 1'b0;
                end
            end else if (phase_q == lpw_pkg::SST_HXT && !hxt_sel) begin
                hto_q   <= 1'b1;
                phase_q <= lto_q ? lpw_pkg::SST_IDLE : lpw_pkg::SST_LXT;
            end else if (phase_q != lpw_pkg::SST_IDLE && sst_tick) begin
                sst_cnt_q <= sst_done ? '0 : sst_cnt_q + 10'h001;
                if (sst_done && phase_q == lpw_pkg::SST_HXT) begin
                    hto_q   <= 1'b1;
                    phase_q <= lto_q ? lpw_pkg::SST_IDLE : lpw_pkg::SST_LXT;
                end else if (sst_done) begin
                    lto_q   <= 1'b1;
                    phase_q <= lpw_pkg::SST_IDLE;
                end
            end
            if (phase_q == lpw_pkg::SST_LXT && !lxt_sel) begin
                lto_q   <= 1'b1;
                phase_q <= lpw_pkg::SST_IDLE;
            end
        end
    end

    // ========================================================================
    // status flags; a set wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdf_q <= 1'b0;
            to_q  <= 1'b0;
        end else if (ce) begin
            if (run_halt) begin
                pdf_q <= 1'b1;
            end else if (clr_wdt) begin
                pdf_q <= 1'b0;
            end
            if (wdt_overflow) begin
                to_q <= 1'b1;
            end else if (run_halt) begin
                to_q <= 1'b0;
            end
        end
    end

    // ========================================================================
    // event pulses
    assign wdt_clr_entry = wdt_en && (ctrl_q[lpw_pkg::CTRL_IDLE_BIT] ?
                           (ctrl_q[lpw_pkg::CTRL_KEEP_BIT] || wdt_src_sub) :
                           (wdt_src_sub || !lvd_en));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_clear     <= 1'b0;
            resume        <= 1'b0;
            irq_take      <= 1'b0;
            sys_reset_req <= 1'b0;
            wdt_reset_req <= 1'b0;
        end else if (ce) begin
            wdt_clear     <= (run_halt && wdt_clr_entry) || (clr_wdt && wdt_en);
            sys_reset_req <= low_pw && ext_reset_req;
            wdt_reset_req <= wdt_overflow;
            irq_take      <= low_pw && !ext_reset_req && !wdt_overflow && take_irq;
            resume        <= low_pw && !ext_reset_req && !wdt_overflow &&
                             !take_irq && (wake_pa || wake_irq);
        end
    end

    // ========================================================================
    // clock gating and hold
    assign sys_clk_en = (state_q == lpw_pkg::ST_RUN) || (state_q == lpw_pkg::ST_FAST) ||
                        (state_q == lpw_pkg::ST_IDL1);
    assign tb_clk_en  = sys_clk_en || (state_q == lpw_pkg::ST_IDL0);
    assign sub_clk_en = (state_q != lpw_pkg::ST_SLP0);
    assign run_on_sub = (state_q == lpw_pkg::ST_FAST);
    assign hxt_osc_en = hxt_sel && (sys_clk_en || state_q == lpw_pkg::ST_STAB);
    assign lxt_osc_en = lxt_sel && sub_clk_en;
    assign cpu_hold   = !((state_q == lpw_pkg::ST_RUN) || (state_q == lpw_pkg::ST_FAST));
    assign freeze     = low_pw;
    assign wdt_run    = wdt_en && !(state_q == lpw_pkg::ST_SLP0) &&
                        (wdt_src_sub || sys_clk_en);

    // ========================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_halt_idle_sys_running;
        run_halt && ctrl_q[lpw_pkg::CTRL_IDLE_BIT] && ctrl_q[lpw_pkg::CTRL_KEEP_BIT];
    endsequence

    property p_slp1_entry;
        run_halt && !ctrl_q[lpw_pkg::CTRL_IDLE_BIT] && (wdt_en || lvd_en)
            |=> state_q == lpw_pkg::ST_SLP1;
    endproperty
    a_slp1_entry: assert property (p_slp1_entry) else $error("no sub sleep");

    property p_slp1_clk;
        state_q == lpw_pkg::ST_SLP1 |-> !sys_clk_en && !tb_clk_en && sub_clk_en && cpu_hold;
    endproperty
    a_slp1_clk: assert property (p_slp1_clk) else $error("sub sleep clocks");

    property p_flags;
        run_halt && !wdt_overflow |=> pdf_q && !to_q;
    endproperty
    a_flags: assert property (p_flags) else $error("halt flags wrong");

    property p_idl0_clk;
        state_q == lpw_pkg::ST_IDL0 |-> !sys_clk_en && tb_clk_en && sub_clk_en;
    endproperty
    a_idl0_clk: assert property (p_idl0_clk) else $error("idle stop clocks");

    property p_idl1;
        s_halt_idle_sys_running |=> state_q == lpw_pkg::ST_IDL1 && sys_clk_en && tb_clk_en;
    endproperty
    a_idl1: assert property (p_idl1) else $error("idle run entry");

    property p_idl1_wdt;
        s_halt_idle_sys_running and wdt_en |=> wdt_clear ##1 !wdt_clear;
    endproperty
    a_idl1_wdt: assert property (p_idl1_wdt) else $error("wdt not cleared");

    property p_pa_wake;
        ce && low_pw && wake_pa && !hxt_sel |=> state_q == lpw_pkg::ST_RUN;
    endproperty
    a_pa_wake: assert property (p_pa_wake) else $error("port wake lost");

    property p_rst_wake;
        ce && low_pw && ext_reset_req |=> sys_reset_req && !irq_take && !resume;
    endproperty
    a_rst_wake: assert property (p_rst_wake) else $error("reset wake");

    property p_stab_hold;
        state_q == lpw_pkg::ST_STAB && !hto_q |=> state_q == lpw_pkg::ST_STAB && cpu_hold;
    endproperty
    a_stab_hold: assert property (p_stab_hold) else $error("ran before ready");

    property p_fast_end;
        ce && state_q == lpw_pkg::ST_FAST && hto_q |=> !run_on_sub && !cpu_hold;
    endproperty
    a_fast_end: assert property (p_fast_end) else $error("fast wake end");

    property p_pdf_clr;
        ce && clr_wdt && !run_halt |=> !pdf_q;
    endproperty
    a_pdf_clr: assert property (p_pdf_clr) else $error("pdf not cleared");

endmodule : lpw_ctrl

/* File: rtl/lpw_pkg.sv */
// Purpose: constants and types of the low-power mode and wake-up controller
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   register map, field positions, reset values and counts
package lpw_pkg;

    // ========================================================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;

    // ========================================================================
    // control register fields
    localparam int         CTRL_IDLE_BIT = 0;
    localparam int         CTRL_KEEP_BIT = 1;
    localparam int         CTRL_FAST_BIT = 2;
    localparam int         CTRL_WDT_LSB  = 4;
    localparam logic [7:0] CTRL_RST      = 8'ha0;
    localparam logic [3:0] WDT_OFF_CODE  = 4'ha;
    localparam logic [7:0] WAKE_RST      = 8'h00;

    // ========================================================================
    // status register fields
    localparam int STAT_PDF_BIT  = 0;
    localparam int STAT_TO_BIT   = 1;
    localparam int STAT_HTO_BIT  = 2;
    localparam int STAT_LTO_BIT  = 3;
    localparam int STAT_MODE_LSB = 4;

    // ========================================================================
    // oscillator stabilisation
    localparam int         SST_CYCLES = 1024;
    localparam logic [9:0] SST_LAST   = 10'(SST_CYCLES - 1);

    // ========================================================================
    // operating states
    typedef enum logic [2:0] {
        ST_RUN  = 3'h0,
        ST_SLP0 = 3'h1,
        ST_SLP1 = 3'h2,
        ST_IDL0 = 3'h3,
        ST_IDL1 = 3'h4,
        ST_STAB = 3'h5,
        ST_FAST = 3'h6
    } lpw_state_e;

    typedef enum logic [1:0] {
        SST_IDLE = 2'h0,
        SST_HXT  = 2'h1,
        SST_LXT  = 2'h2
    } lpw_sst_e;

endpackage : lpw_pkg

/* File: rtl/lpw_pin_sync.sv */
// Purpose: three-stage synchroniser with edge pulses for pin inputs
// Assumes: pins are asynchronous to pclk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module lpw_pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // pins and edges
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] lvl_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ========================================================================
    // per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= '1;
        end else if (ce) begin
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rise  = ce ? (lvl_d & ~lvl_q) : '0;
    assign fall  = ce ? (~lvl_d & lvl_q) : '0;

endmodule : lpw_pin_sync

/* File: verif/lpw_osc_model.sv */
// Purpose: crystal tick model beside the low-power controller
// Assumes: a crystal only ticks while its enable is high
// Notes:   hxt period 8 pclk cycles, lxt 12; toggles avoid rising pclk edges
`timescale 1ns/1ps
module lpw_osc_model (
    // oscillator enables
    input  wire logic hxt_osc_en,
    input  wire logic lxt_osc_en,
    // ticks
    output logic      hxt_tick,
    output logic      lxt_tick
);
    // ==========
    // ticks stand still while off
    initial begin
        hxt_tick = 1'b0;
        forever #80 if (hxt_osc_en) hxt_tick = ~hxt_tick;
    end
    initial begin
        lxt_tick = 1'b0;
        forever #120 if (lxt_osc_en) lxt_tick = ~lxt_tick;
    end
endmodule : lpw_osc_model

/* File: verif/test_low_power_mode_wake_control.sv */
// Purpose: self-checking bench of the low-power controller
// Assumes: hxt ticks every 8 cycles, lxt every 12
// Notes:   one task per scenario
`timescale 1ns/1ps
module test_low_power_mode_wake_control;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        halt, clr_wdt, sf, cfg, src, low_voltage_detect, hsel, lsel, xrst, ovf;
    logic        hxt_tick, lxt_tick, sys_en, tb_en, sub_en, on_sub, hxt_en, lxt_en;
    logic        hold, frz, rsm, take, srst, wrst, wclr, wrun;
    logic [7:0]  paddr, irq, ien, pa;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, checks;
    // ==========
    lpw_ctrl u_lpw_ctrl (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .halt, .clr_wdt, .stack_full(sf),
        .irq_req(irq), .irq_en(ien), .wdt_cfg_en(cfg), .wdt_src_sub(src), .lvd_en(low_voltage_detect),
        .hxt_sel(hsel), .lxt_sel(lsel), .ext_reset_req(xrst), .wdt_overflow(ovf),
        .port_a(pa), .hxt_tick, .lxt_tick, .sys_clk_en(sys_en), .tb_clk_en(tb_en),
        .sub_clk_en(sub_en), .run_on_sub(on_sub), .hxt_osc_en(hxt_en),
        .lxt_osc_en(lxt_en), .cpu_hold(hold), .freeze(frz), .resume(rsm),
        .irq_take(take), .sys_reset_req(srst), .wdt_reset_req(wrst),
        .wdt_clear(wclr), .wdt_run(wrun));
    lpw_osc_model u_lpw_osc_model (.hxt_osc_en(hxt_en), .lxt_osc_en(lxt_en), .hxt_tick,
        .lxt_tick);
    always #10 pclk = ~pclk;
    // ==========
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic stat(input logic [7:0] e);
        apb(1'b0, lpw_pkg::ADDR_STAT, 32'h0);
        cmp(rd & 32'h77, {25'h0, e});
    endtask : stat
    task automatic do_halt;
        @(posedge pclk);
        halt <= 1'b1;
        @(posedge pclk);
        halt <= 1'b0;
        #1;
    endtask : do_halt
    task automatic wake(input logic [3:0] e);
        logic [3:0] s;
        s = 4'h0;
        repeat (8) begin
            #1;
            s |= {srst, wrst, take, rsm};
            @(posedge pclk);
        end
        cmp(s, e);
    endtask : wake
    // ==========
    task automatic reset_case;
        apb(1'b0, lpw_pkg::ADDR_CTRL, 32'h0);
        cmp(rd, lpw_pkg::CTRL_RST);
        apb(1'b0, lpw_pkg::ADDR_WAKE, 32'h0);
        cmp(rd, lpw_pkg::WAKE_RST);
        apb(1'b1, lpw_pkg::ADDR_STAT, 32'hff);
        stat(8'h04);
        apb(1'b0, 8'h0c, 32'h0);
        cmp({err, rd}, {1'b1, 32'h0});
    endtask : reset_case
    task automatic mode_case(input logic [7:0] c, input logic [2:0] k, input logic [2:0] st,
                             input logic [3:0] en);
        apb(1'b1, lpw_pkg::ADDR_CTRL, {24'h0, c});
        {cfg, low_voltage_detect, src} <= k;
        do_halt;
        cmp({sys_en, tb_en, sub_en, wclr, wrun}, {en, en[0]});
        cmp({hold, frz}, 2'b11);
        stat({1'b0, st, 4'h5});
        pa <= 8'hfd;
        repeat (8) @(posedge pclk);
        #1;
        cmp(hold, 1'b1);
        @(posedge pclk);
        pa <= 8'hfc;
        wake(4'b0001);
        stat(8'h05);
        pa <= 8'hff;
        repeat (6) @(posedge pclk);
    endtask : mode_case
    task automatic evt_case(input logic x);
        apb(1'b1, lpw_pkg::ADDR_CTRL, 32'h50);
        do_halt;
        @(posedge pclk);
        xrst <= x;
        ovf  <= ~x;
        @(posedge pclk);
        xrst <= 1'b0;
        ovf  <= 1'b0;
        wake(x ? 4'b1000 : 4'b0100);
        if (!x) begin
            stat(8'h07);
            clr_wdt <= 1'b1;
            @(posedge pclk);
            clr_wdt <= 1'b0;
            stat(8'h06);
        end
    endtask : evt_case
    task automatic irq_case(input logic s, input logic [3:0] e);
        apb(1'b1, lpw_pkg::ADDR_CTRL, 32'ha3);
        irq <= 8'h02;
        ien <= 8'h06;
        sf  <= s;
        do_halt;
        repeat (6) @(posedge pclk);
        irq <= 8'h06;
        #1;
        cmp(hold, 1'b1);
        wake(e);
        irq <= 8'h00;
    endtask : irq_case
    task automatic hxt_case(input logic [7:0] c, input logic e);
        int n;
        n = 0;
        apb(1'b1, lpw_pkg::ADDR_CTRL, {24'h0, c});
        {cfg, low_voltage_detect, src} <= 3'b001;
        hsel <= 1'b1;
        lsel <= ~e;
        do_halt;
        @(posedge pclk);
        pa <= 8'hfe;
        repeat (6) @(posedge pclk);
        #1;
        cmp({on_sub, hxt_en, lxt_en}, {e, 1'b1, ~e});
        while ((hold | on_sub) === 1'b1 && n < 20000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        cmp((n > 8000) && (n < 8400), 1'b1);
        @(posedge pclk);
        pa   <= 8'hff;
        hsel <= 1'b0;
        if (!e) begin
            apb(1'b0, lpw_pkg::ADDR_STAT, 32'h0);
            cmp(rd[3:2], 2'b01);
            repeat (11000) @(posedge pclk);
            apb(1'b0, lpw_pkg::ADDR_STAT, 32'h0);
            cmp(rd[3], 1'b0);
            repeat (1500) @(posedge pclk);
            apb(1'b0, lpw_pkg::ADDR_STAT, 32'h0);
            cmp(rd[3], 1'b1);
        end
    endtask : hxt_case
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // ==========
    initial begin
        {presetn, psel, penable, pwrite, halt, clr_wdt, sf} = 7'h00;
        {cfg, src, low_voltage_detect, hsel, lsel, xrst, ovf, paddr, irq, ien, pwdata} = 63'h0;
        pa = 8'hff;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        reset_case;
        apb(1'b1, lpw_pkg::ADDR_WAKE, 32'h1);
        mode_case(8'ha0, 3'b001, 3'h1, 4'b0000);
        mode_case(8'h50, 3'b001, 3'h2, 4'b0011);
        mode_case(8'ha0, 3'b010, 3'h2, 4'b0010);
        mode_case(8'h51, 3'b001, 3'h3, 4'b0111);
        mode_case(8'h51, 3'b000, 3'h3, 4'b0110);
        mode_case(8'ha3, 3'b010, 3'h4, 4'b1110);
        mode_case(8'h53, 3'b000, 3'h4, 4'b1111);
        evt_case(1'b1);
        evt_case(1'b0);
        irq_case(1'b0, 4'b0010);
        irq_case(1'b1, 4'b0001);
        hxt_case(8'h54, 1'b1);
        hxt_case(8'ha4, 1'b0);
        final_report;
    end
    initial begin
        #1_000_000;
        miscompares++;
        final_report;
    end
endmodule : test_low_power_mode_wake_control
